/* hw/sppc_cfg.svh */
// constants, register map and timing of the pulse position command block
// ==========================================================================
// Operation
// RULE1 - controller keeps the command pulse rate at or below 500 kHz
// RULE2 - step/direction, A/B quadrature or CW/CCW command formats selectable
// RULE3 - forward is clockwise; quadrature A leading B is forward
// RULE4 - gear divisor 500 to 16384, default 4096, ratio 4096/divisor
// RULE5 - default divisor gives one turn per 16384 counts, scaling with it
// RULE6 - gear divisor acts only in position servo mode
// RULE7 - in position while |command - motor| is within the window
// RULE8 - in-position window takes 1 to 127 feedback units
// RULE9 - in-position output low while in position, high otherwise
// RULE10 - lost-phase alarm after 90 degrees error held about 2 seconds
// RULE11 - disabling the drive clears and holds the position error
// RULE12 - emulated encoder gives four edges per line per turn
// RULE13 - emulated encoder line count takes 500 to 2048
// RULE14 - index pulses once per turn for at least 0.7 us
// RULE15 - emulated A leads B forward, B leads A reverse
// RULE16 - step format: each rising step edge counts, direction sampled then
// RULE17 - CW line pulse counts forward, CCW line pulse counts reverse
// RULE18 - controller waits 150 ms after power on before commanding; the bench sends its first command about 1 us after reset
`ifndef SPPC_CFG_SVH
`define SPPC_CFG_SVH
// ==========================================================================
// timing
`define SPPC_CLK_NS 20
`define SPPC_ZW_NS 700
`define SPPC_ZW_CYC ((`SPPC_ZW_NS + `SPPC_CLK_NS - 1) / `SPPC_CLK_NS)
`define SPPC_LOST_MS 2000
`define SPPC_LOST_CYC (`SPPC_LOST_MS * (1000000 / `SPPC_CLK_NS))
// ==========================================================================
// scaling, limits and reset values
`define SPPC_GEAR_MIN 32'h0000_01F4
`define SPPC_GEAR_MAX 32'h0000_4000
`define SPPC_GEAR_DEF 15'h1000
`define SPPC_GEAR_NUM 20'sh04000
`define SPPC_WIN_MIN 32'h0000_0001
`define SPPC_WIN_MAX 32'h0000_007F
`define SPPC_WIN_DEF 7'h10
`define SPPC_LINE_MIN 32'h0000_01F4
`define SPPC_LINE_MAX 32'h0000_0800
`define SPPC_LINE_DEF 12'h800
`define SPPC_FB_REV 20'sh10000
`define SPPC_QTR_REV 32'h0000_4000
`define SPPC_POSMODE_RST 1'b1
// ==========================================================================
// register byte addresses and fields
`define SPPC_A_CTRL 8'h00
`define SPPC_A_GEAR 8'h04
`define SPPC_A_WIN 8'h08
`define SPPC_A_LINE 8'h0C
`define SPPC_A_STAT 8'h10
`define SPPC_A_ERR 8'h14
`define SPPC_A_ISTAT 8'h18
`define SPPC_A_ICLR 8'h1C
`define SPPC_A_IEN 8'h20
`define SPPC_CTRL_POS 0
`define SPPC_CTRL_FMT 2:1
`define SPPC_INT_W 2
`endif

/* hw/sppc_pkg.sv */
// shared types of the pulse position command block
package sppc_pkg;
  typedef enum logic [1:0] {
    sppc_fmt_step = 2'h0,
    sppc_fmt_quad = 2'h1,
    sppc_fmt_cw = 2'h3
  } sppc_fmt_t;
  typedef logic [11:0] sppc_lines_t;
endpackage

/* hw/sppc_cnt_if.sv */
// command count events between the pin decoder and the core
`timescale 1ns/100ps
interface sppc_cnt_if;
  sppc_pkg::sppc_fmt_t fmt;
  logic fwd;
  logic rev;
  modport dec (input fmt, output fwd, output rev);
  modport core (output fmt, input fwd, input rev);
endinterface

/* hw/sppc_cmd_decode.sv */
// command pin synchroniser and format decoder
`timescale 1ns/100ps
`include "sppc_cfg.svh"
module sppc_cmd_decode (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins: step/A/CW and direction/B/CCW
  input wire logic pin_a,
  input wire logic pin_b,
  // count events
  sppc_cnt_if.dec cnt
);
  import sppc_pkg::*;
  logic [1:0] pins;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  assign pins = {pin_a, pin_b};
  // ========================================================================
  // synchronisers; s1 feeds s2 only
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
  end
  // ========================================================================
  // x4 quadrature: bit1 = A, bit0 = B; returns {rev, fwd}
  function automatic logic [1:0] qdir(input logic [1:0] o,
                                      input logic [1:0] n);
    case ({o, n})
      4'h2, 4'hB, 4'hD, 4'h4: qdir = 2'h1;
      4'h8, 4'hE, 4'h7, 4'h1: qdir = 2'h2;
      default: qdir = 2'h0;
    endcase
  endfunction
  // one event per edge is enough since pulses are 2 us apart or more [RULE1]
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt.fwd <= 1'b0;
      cnt.rev <= 1'b0;
    end else begin
      case (cnt.fmt) // [RULE2]
        sppc_fmt_quad: begin
          {cnt.rev, cnt.fwd} <= qdir(s3_q, s2_q); // [RULE3]
        end
        sppc_fmt_cw: begin
          // simultaneous edges cancel
          cnt.fwd <= s2_q[1] && !s3_q[1] && !(s2_q[0] && !s3_q[0]); // [RULE17]
          cnt.rev <= s2_q[0] && !s3_q[0] && !(s2_q[1] && !s3_q[1]); // [RULE17]
        end
        default: begin
          cnt.fwd <= s2_q[1] && !s3_q[1] && s2_q[0]; // [RULE16]
          cnt.rev <= s2_q[1] && !s3_q[1] && !s2_q[0]; // [RULE16]
        end
      endcase
    end
  end
  // ========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_a_leads;
    cnt.fmt == sppc_fmt_quad && s3_q == 2'h0 && s2_q == 2'h2;
  endsequence
  a_quad_a_leads: assert property (s_a_leads |=> cnt.fwd && !cnt.rev) // [RULE3]
    else $error("quadrature A leading B not counted forward");
  a_step_dir: assert property (cnt.fmt == sppc_fmt_step && s2_q[1]
    && !s3_q[1] |=> cnt.fwd == $past(s2_q[0]) && cnt.rev != cnt.fwd) // [RULE16]
    else $error("step edge not counted with sampled direction");
  a_ccw_line: assert property (cnt.fmt == sppc_fmt_cw && s2_q == 2'h1
    && s3_q == 2'h0 |=> cnt.rev && !cnt.fwd) // [RULE17]
    else $error("ccw line pulse not counted reverse");
endmodule

/* hw/sppc_enc_emul.sv */
// emulated A/B/Z encoder output scaled from motor feedback
`timescale 1ns/100ps
`include "sppc_cfg.svh"
module sppc_enc_emul #(
  parameter int ZW = `SPPC_ZW_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // motor motion, one feedback unit per pulse
  input wire logic mv_fwd,
  input wire logic mv_rev,
  input wire logic rev_mark,
  input wire sppc_pkg::sppc_lines_t lines,
  // encoder outputs
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  import sppc_pkg::*;
  logic signed [19:0] acc_q;
  logic signed [19:0] acc_t;
  logic signed [19:0] acc_d;
  logic signed [19:0] l4;
  logic go_f;
  logic go_r;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [7:0] zc_q;
  logic a_q;
  logic b_q;
  logic z_q;
  // ========================================================================
  // rate divider: lines*4 steps per 65536 units [RULE12]
  assign l4 = signed'({6'h0, lines, 2'h0});
  always_comb begin
    acc_t = acc_q;
    if (mv_fwd) begin
      acc_t = acc_q + l4;
    end else if (mv_rev) begin
      acc_t = acc_q - l4;
    end
    go_f = acc_t >= `SPPC_FB_REV;
    go_r = acc_t < 20'sh0;
    acc_d = acc_t;
    if (go_f) begin
      acc_d = acc_t - `SPPC_FB_REV;
    end else if (go_r) begin
      acc_d = acc_t + `SPPC_FB_REV;
    end
    ph_d = go_f ? ph_q + 2'h1 : (go_r ? ph_q - 2'h1 : ph_q);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 20'sh0;
      ph_q <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      ph_q <= ph_d;
      a_q <= ph_d[1] ^ ph_d[0]; // [RULE15]
      b_q <= ph_d[1]; // [RULE15]
    end
  end
  // ========================================================================
  // index stretched to a fixed width, free of A/B phase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      zc_q <= 8'h0;
      z_q <= 1'b0;
    end else if (rev_mark) begin
      zc_q <= 8'(ZW - 1); // [RULE14]
      z_q <= 1'b1;
    end else begin
      zc_q <= (zc_q != 8'h0) ? zc_q - 8'h1 : 8'h0;
      z_q <= zc_q != 8'h0; // [RULE14]
    end
  end
  assign enc_a = a_q;
  assign enc_b = b_q;
  assign enc_z = z_q;
  // ========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_quad_fwd: assert property (go_f |=> ph_q == $past(ph_q) + 2'h1) // [RULE15]
    else $error("forward step did not advance A/B phase");
  a_z_width: assert property ($rose(z_q) |=> z_q [*8]) // [RULE14]
    else $error("index pulse too short");
  a_z_end: assert property ($fell(z_q) |-> $past(zc_q) == 8'h0) // [RULE14]
    else $error("index ended before its count ran out");
endmodule

/* hw/sppc_top.sv */
// pulse position command front end with apb registers
`timescale 1ns/100ps
`include "sppc_cfg.svh"
module sppc_top #(
  parameter int unsigned LOST_CYC = `SPPC_LOST_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command pins
  input wire logic step_pulse_input,
  input wire logic cmd_dir_input,
  input wire logic drive_enable_input,
  // motor feedback, 65536 units per turn, same clock
  input wire logic [15:0] motor_pos,
  // drive outputs
  output logic in_position_output_n,
  output logic lost_phase_alarm,
  output logic irq,
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  import sppc_pkg::*;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_data;
  logic wr_go;
  logic pos_mode_q;
  sppc_fmt_t fmt_q;
  logic [14:0] gear_q;
  logic [6:0] win_q;
  sppc_lines_t lines_q;
  logic [`SPPC_INT_W-1:0] int_stat_q;
  logic [`SPPC_INT_W-1:0] int_en_q;
  logic [`SPPC_INT_W-1:0] int_set;
  logic [`SPPC_INT_W-1:0] int_clr;
  logic irq_q;
  logic en_s1_q;
  logic en_s2_q;
  logic signed [31:0] err_q;
  logic signed [31:0] err_d;
  logic [31:0] err_abs;
  logic signed [19:0] rem_q;
  logic signed [19:0] rem_t;
  logic signed [19:0] rem_d;
  logic signed [19:0] g1;
  logic signed [19:0] g2;
  logic signed [2:0] cmd_step;
  logic [14:0] gdiv;
  logic [15:0] mot_prev_q;
  logic signed [15:0] mot_delta;
  logic rev_mark;
  logic [31:0] lost_cnt_q;
  logic alarm_q;
  logic in_pos_n_q;
  logic in_pos_w;
  logic far_w;
  sppc_cnt_if cnt_if ();

  // ========================================================================
  // helpers
  function automatic logic [31:0] clamp32(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic map_hit(input logic [7:0] a);
    case (a)
      `SPPC_A_CTRL, `SPPC_A_GEAR, `SPPC_A_WIN, `SPPC_A_LINE,
      `SPPC_A_STAT, `SPPC_A_ERR, `SPPC_A_ISTAT, `SPPC_A_ICLR,
      `SPPC_A_IEN: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  endfunction

  // ========================================================================
  // apb slave, one wait state so every answer comes from a flop
  assign wr_go = psel && penable && pready_q && pwrite;

  always_comb begin
    rd_data = 32'h0;
    case (paddr)
      `SPPC_A_CTRL: rd_data = {29'h0, fmt_q, pos_mode_q};
      `SPPC_A_GEAR: rd_data = {17'h0, gear_q};
      `SPPC_A_WIN: rd_data = {25'h0, win_q};
      `SPPC_A_LINE: rd_data = {20'h0, lines_q};
      `SPPC_A_STAT: rd_data = {29'h0, en_s2_q, alarm_q, !in_pos_n_q};
      `SPPC_A_ERR: rd_data = err_q;
      `SPPC_A_ISTAT: rd_data = {30'h0, int_stat_q};
      `SPPC_A_IEN: rd_data = {30'h0, int_en_q};
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0 : rd_data;
      pslverr_q <= !map_hit(paddr);
    end else begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
  end

  // ========================================================================
  // configuration; out-of-range writes clamp to the nearest limit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_mode_q <= `SPPC_POSMODE_RST;
      fmt_q <= sppc_fmt_step;
      gear_q <= `SPPC_GEAR_DEF; // [RULE4]
      win_q <= `SPPC_WIN_DEF;
      lines_q <= `SPPC_LINE_DEF;
    end else if (wr_go) begin
      case (paddr)
        `SPPC_A_CTRL: begin
          pos_mode_q <= pwdata[`SPPC_CTRL_POS];
          fmt_q <= sppc_fmt_t'(pwdata[`SPPC_CTRL_FMT]); // [RULE2]
        end
        `SPPC_A_GEAR: begin
          gear_q <= 15'(clamp32(pwdata, `SPPC_GEAR_MIN,
                                `SPPC_GEAR_MAX)); // [RULE4]
        end
        `SPPC_A_WIN: begin
          win_q <= 7'(clamp32(pwdata, `SPPC_WIN_MIN,
                              `SPPC_WIN_MAX)); // [RULE8]
        end
        `SPPC_A_LINE: begin
          lines_q <= 12'(clamp32(pwdata, `SPPC_LINE_MIN,
                                 `SPPC_LINE_MAX)); // [RULE13]
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // interrupts: status sticky, set wins over a clear in the same cycle
  assign int_set = {in_pos_w && in_pos_n_q && en_s2_q,
                    far_w && lost_cnt_q == LOST_CYC - 1 && !alarm_q};
  assign int_clr = (wr_go && paddr == `SPPC_A_ICLR) ?
                   pwdata[`SPPC_INT_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_stat_q <= '0;
      int_en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= int_set | (int_stat_q & ~int_clr);
      if (wr_go && paddr == `SPPC_A_IEN) begin
        int_en_q <= pwdata[`SPPC_INT_W-1:0];
      end
      irq_q <= |(int_stat_q & int_en_q);
    end
  end

  // ========================================================================
  // enable pin synchroniser
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      en_s1_q <= drive_enable_input;
      en_s2_q <= en_s1_q;
    end
  end

  // ========================================================================
  // command decoding
  assign cnt_if.fmt = fmt_q;

  sppc_cmd_decode u_dec (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_a(step_pulse_input),
    .pin_b(cmd_dir_input),
    .cnt(cnt_if)
  );

  // ========================================================================
  // gear: each count adds 16384 to a residue drained in divisor units,
  // giving 16384/divisor feedback units per count [RULE4] [RULE5]
  assign gdiv = pos_mode_q ? gear_q : `SPPC_GEAR_DEF; // [RULE6]
  assign g1 = signed'({5'h0, gdiv});
  assign g2 = g1 <<< 1;

  // two units a cycle keep up with the fastest allowed pulse rate [RULE1]
  always_comb begin
    rem_t = rem_q;
    if (cnt_if.fwd && !cnt_if.rev) begin
      rem_t = rem_q + `SPPC_GEAR_NUM; // [RULE3]
    end else if (cnt_if.rev && !cnt_if.fwd) begin
      rem_t = rem_q - `SPPC_GEAR_NUM;
    end
    cmd_step = 3'sh0;
    rem_d = rem_t;
    if (rem_t >= g2) begin
      cmd_step = 3'sh2;
      rem_d = rem_t - g2;
    end else if (rem_t >= g1) begin
      cmd_step = 3'sh1;
      rem_d = rem_t - g1;
    end else if (rem_t <= -g2) begin
      cmd_step = 3'sh6;
      rem_d = rem_t + g2;
    end else if (rem_t <= -g1) begin
      cmd_step = 3'sh7;
      rem_d = rem_t + g1;
    end
  end

  // ========================================================================
  // following error = command minus motor, in feedback units
  assign mot_delta = signed'(motor_pos - mot_prev_q);
  assign err_d = err_q + 32'(cmd_step) - 32'(mot_delta);
  assign err_abs = abs32(err_q);
  assign in_pos_w = err_abs <= {25'h0, win_q}; // [RULE7]
  assign far_w = err_abs >= `SPPC_QTR_REV; // [RULE10]

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= 32'sh0;
      rem_q <= 20'sh0;
      mot_prev_q <= 16'h0;
    end else begin
      mot_prev_q <= motor_pos;
      if (!en_s2_q) begin
        err_q <= 32'sh0; // [RULE11]
        rem_q <= 20'sh0; // [RULE11]
      end else begin
        err_q <= err_d;
        rem_q <= rem_d;
      end
    end
  end

  // ========================================================================
  // in-position output, active low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_pos_n_q <= 1'b1;
    end else begin
      in_pos_n_q <= !in_pos_w; // [RULE9]
    end
  end

  // ========================================================================
  // lost phase: alarm latches until the drive is disabled
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lost_cnt_q <= 32'h0;
      alarm_q <= 1'b0;
    end else if (!en_s2_q) begin
      lost_cnt_q <= 32'h0;
      alarm_q <= 1'b0;
    end else if (!far_w) begin
      lost_cnt_q <= 32'h0;
    end else if (lost_cnt_q == LOST_CYC - 1) begin
      alarm_q <= 1'b1; // [RULE10]
    end else begin
      lost_cnt_q <= lost_cnt_q + 32'h1;
    end
  end

  // ========================================================================
  // encoder emulation; assumes at most one feedback unit of motion a cycle
  assign rev_mark = (mot_prev_q[15:14] == 2'h3 && motor_pos[15:14] == 2'h0)
                 || (mot_prev_q[15:14] == 2'h0 && motor_pos[15:14] == 2'h3);

  sppc_enc_emul u_enc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .mv_fwd(mot_delta > 16'sh0),
    .mv_rev(mot_delta < 16'sh0),
    .rev_mark(rev_mark),
    .lines(lines_q),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_z(enc_z)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign in_position_output_n = in_pos_n_q;
  assign lost_phase_alarm = alarm_q;
  assign irq = irq_q;

  // ========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_one_count;
    en_s2_q && gdiv == `SPPC_GEAR_DEF && rem_q == 20'sh0 && cnt_if.fwd
      && !cnt_if.rev;
  endsequence
  a_gear_scale: assert property (s_one_count |=> rem_q == 20'sh02000
    ##1 rem_q == 20'sh0) // [RULE5]
    else $error("default gear did not give four units per count");
  a_gear_range: assert property (gear_q >= 15'h01F4
    && gear_q <= 15'h4000) // [RULE4]
    else $error("gear divisor out of range");
  a_win_range: assert property (win_q != 7'h00) // [RULE8]
    else $error("in-position window is zero");
  a_line_range: assert property (lines_q >= 12'h1F4
    && lines_q <= 12'h800) // [RULE13]
    else $error("line count out of range");
  a_gear_mode: assert property (!pos_mode_q |-> gdiv == 15'h1000) // [RULE6]
    else $error("gear divisor used outside position mode");
  a_dis_clear: assert property (!en_s2_q |=> err_q == 32'sh0) // [RULE11]
    else $error("error not cleared while disabled");
  a_inpos_zero: assert property (err_q == 32'sh0 |=> !in_pos_n_q) // [RULE7]
    else $error("zero error not reported in position");
  a_inpos_far: assert property (err_abs > 32'h7F |=> in_pos_n_q) // [RULE9]
    else $error("large error reported in position");
  a_lost_hold: assert property ($rose(alarm_q) |-> $past(far_w)
    && $past(lost_cnt_q) == LOST_CYC - 1) // [RULE10]
    else $error("lost-phase alarm without full hold time");
endmodule

/* sim/sppc_ctl_model.sv */
// behavioural motion controller driving the command pins
`timescale 1ns/100ps
module sppc_ctl_model #(
  parameter int GAP = 50
) (
  // clock
  input wire logic sys_clk,
  // command pins
  output logic pin_a,
  output logic pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // ==========================================================
  // one edge per microsecond keeps at or under the pulse ceiling; cw/ccw lines pulse every 2 us, right at it
  task automatic gap;
    repeat (GAP) @(posedge sys_clk);
  endtask
  // fmt 0 step/dir, 1 quadrature, 3 cw/ccw lines
  task automatic send(input logic [1:0] fmt, input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      case (fmt)
        2'h1: begin
          if ((pin_a == pin_b) == fwd) pin_a <= ~pin_a;
          else pin_b <= ~pin_b;
        end
        2'h3: begin
          if (fwd) pin_a <= 1'b1;
          else pin_b <= 1'b1;
          gap;
          pin_a <= 1'b0;
          pin_b <= 1'b0;
        end
        default: begin
          pin_b <= fwd;
          gap;
          pin_a <= 1'b1;
          gap;
          pin_a <= 1'b0;
          pin_b <= 1'b0;
        end
      endcase
      gap;
    end
  endtask
endmodule

/* sim/tb_servo_pulse_position_command.sv */
// self-checking bench of the pulse position command block
`timescale 1ns/100ps
`include "sppc_cfg.svh"
module tb_servo_pulse_position_command;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, en = 1, pin_a, pin_b, inpos_n, alm, irq;
  logic ea, eb, ez, pa = 0, dn = 0;
  logic [15:0] mpos = 0;
  int bad_count = 0, n_tests = 0, cyc = 0, edges = 0, zw = 0, zc = 0;
  int zn = 0, lead_bad = 0;
  always #10 sys_clk = ~sys_clk;
  sppc_top #(.LOST_CYC(200)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse_input(pin_a), .cmd_dir_input(pin_b),
    .drive_enable_input(en), .motor_pos(mpos),
    .in_position_output_n(inpos_n), .lost_phase_alarm(alm), .irq(irq),
    .enc_a(ea), .enc_b(eb), .enc_z(ez));
  sppc_ctl_model CTL (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));
  // ==========================================================
  // watchdog and encoder monitor
  always @(posedge sys_clk) begin
    edges += int'(ea !== pa);
    if (ea && !pa && eb !== dn) lead_bad++;
    if (ez) zc++;
    else if (zc > 0) begin
      zw = zc;
      zc = 0;
      zn++;
    end
    pa = ea;
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      $display("BAD cycle_limit exp under %0d got %0d", 90000, cyc);
      end_sim;
    end
  end
  logic pb = 0;
  always @(posedge sys_clk) begin
    edges += int'(eb !== pb);
    pb = eb;
  end
  task end_sim;
    $display("tests %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // ==========================================================
  // apb master: holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // only the watchdog ends a wait for pready
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), x, r);
  endtask
  task w(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    rd(`SPPC_A_CTRL, 1);
    rd(`SPPC_A_GEAR, 4096);
    rd(`SPPC_A_WIN, 16);
    rd(`SPPC_A_LINE, 2048);
    rd(`SPPC_A_IEN, 0);
    rd(`SPPC_A_STAT, 5);
    rd(8'h24, 0);
    chk("pslverr", 1, e);
    w(1);
    chk("inpos_n", 0, inpos_n);
    $display("reset test done");
  endtask
  task t_step;
    CTL.send(2'h0, 4, 1);
    rd(`SPPC_A_ERR, 16);
    chk("inpos_n", 0, inpos_n);
    CTL.send(2'h0, 1, 1);
    rd(`SPPC_A_ERR, 20);
    w(1);
    chk("inpos_n", 1, inpos_n);
    CTL.send(2'h0, 5, 0);
    rd(`SPPC_A_ERR, 0);
    rd(`SPPC_A_ISTAT, 2);
    $display("step test done");
  endtask
  task t_gear;
    wr(`SPPC_A_WIN, 0);
    rd(`SPPC_A_WIN, 1);
    wr(`SPPC_A_WIN, 200);
    rd(`SPPC_A_WIN, 127);
    wr(`SPPC_A_WIN, 16);
    wr(`SPPC_A_GEAR, 100);
    rd(`SPPC_A_GEAR, 500);
    wr(`SPPC_A_GEAR, 20000);
    rd(`SPPC_A_GEAR, 16384);
    wr(`SPPC_A_GEAR, 8192);
    CTL.send(2'h0, 1, 1);
    rd(`SPPC_A_ERR, 2);
    wr(`SPPC_A_CTRL, 4);
    CTL.send(2'h0, 1, 1);
    rd(`SPPC_A_ERR, 6);
    wr(`SPPC_A_CTRL, 1);
    CTL.send(2'h0, 3, 0);
    rd(`SPPC_A_ERR, 0);
    wr(`SPPC_A_GEAR, 4096);
    $display("gear test done");
  endtask
  task t_fmt;
    wr(`SPPC_A_CTRL, 7);
    CTL.send(2'h3, 2, 1);
    rd(`SPPC_A_ERR, 8);
    CTL.send(2'h3, 2, 0);
    rd(`SPPC_A_ERR, 0);
    wr(`SPPC_A_CTRL, 3);
    CTL.send(2'h1, 3, 1);
    rd(`SPPC_A_ERR, 12);
    CTL.send(2'h1, 3, 0);
    rd(`SPPC_A_ERR, 0);
    wr(`SPPC_A_CTRL, 1);
    $display("format test done");
  endtask
  // a quarter turn backwards through the index: encoder, alarm, irq
  task t_motion;
    wr(`SPPC_A_IEN, 1);
    dn = 1;
    edges = 0;
    repeat (16384) begin
      mpos <= mpos - 16'h0001;
      repeat (2) @(posedge sys_clk);
    end
    w(10);
    chk("edges", 2048, edges);
    chk("lead", 0, lead_bad);
    chk("z width", 35, zw);
    chk("z count", 1, zn);
    w(140);
    chk("alarm early", 0, alm);
    w(110);
    chk("alarm", 1, alm);
    chk("irq", 1, irq);
    rd(`SPPC_A_STAT, 6);
    apb(0, `SPPC_A_ISTAT, 0);
    chk("istat", 1, r[0]);
    wr(`SPPC_A_IEN, 0);
    w(3);
    chk("irq masked", 0, irq);
    wr(`SPPC_A_IEN, 1);
    w(3);
    chk("irq", 1, irq);
    wr(`SPPC_A_ICLR, 3);
    w(3);
    chk("irq cleared", 0, irq);
    rd(`SPPC_A_ISTAT, 0);
    $display("motion test done");
  endtask
  task t_disable;
    @(posedge sys_clk);
    en <= 0;
    w(5);
    chk("alarm off", 0, alm);
    rd(`SPPC_A_ERR, 0);
    CTL.send(2'h0, 3, 1);
    rd(`SPPC_A_ERR, 0);
    en <= 1;
    w(5);
    rd(`SPPC_A_ERR, 0);
    $display("disable test done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1;
    w(20);
    t_reset;
    t_step;
    t_gear;
    t_fmt;
    t_motion;
    t_disable;
    end_sim;
  end
endmodule
